// [rtl/csf_regs.sv]
// Special function registers: indirect access, work register, pcl, table, flags
module csf_regs
  import csf_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int BANK_W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Data access request from the execution core
  input wire logic acc_rd_i,
  input wire logic acc_wr_i,
  input wire logic [7:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic [7:0] acc_rdata_o,
  // Resolved data memory port towards the general RAM
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [BANK_W+7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // Work register load from the ALU path
  input wire logic work_ld_i,
  input wire logic [7:0] work_d_i,
  output logic [7:0] work_register_o,
  // Alu flag update
  input wire logic [2:0] alu_op_i,
  input wire logic [7:0] alu_a_i,
  input wire logic [7:0] alu_b_i,
  input wire logic alu_zero_upd_i,
  output logic [7:0] alu_result_o,
  // Program counter and fetch control
  input wire logic pc_step_i,
  output logic [PC_W-1:0] pc_o,
  output logic fetch_stall_o,
  // Table read
  input wire logic tbl_rd_i,
  input wire logic [15:0] tbl_word_i,
  output logic [7:0] table_pointer_o,
  output logic [7:0] tbl_low_o,
  // System events
  input wire logic watchdog_clear_instruction_i,
  input wire logic halt_i,
  input wire logic wdt_timeout_i,
  output logic [7:0] flags_o
);
  // A page needs bits above the low byte; the bank field must fit the select byte
  if (PC_W < 9 || PC_W > 16) begin : g_bad_pc_w
    $error("PC_W must be 9..16");
  end
  if (BANK_W < 1 || BANK_W > 7) begin : g_bad_bank_w
    $error("BANK_W must be 1..7");
  end

  logic [7:0] ptr_a_q, ptr_b_q, bank_q, work_q, table_pointer_q, table_high_byte_q, lo_q;
  logic [5:0] flags_q;
  logic [PC_W-1:0] pc_q;
  logic dummy_q;
  logic sel_a, sel_b, sel_virt, sel_mem, indirect;
  logic [7:0] eff_addr;
  logic [BANK_W-1:0] eff_bank;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] low7; // Top bit is the carry into bit 7
  logic [7:0] res;
  logic c_new, ac_new, ov_new, arith;

  // Decode virtual registers and form the real target
  assign sel_a = acc_addr_i == CSF_ADDR_VIND_A;
  assign sel_b = acc_addr_i == CSF_ADDR_VIND_B;
  assign indirect = sel_a | sel_b;
  always_comb begin
    eff_addr = acc_addr_i;
    eff_bank = '0;
    if (sel_a) begin
      eff_addr = ptr_a_q;
      eff_bank = '0;
    end else if (sel_b) begin
      eff_addr = ptr_b_q;
      eff_bank = bank_q[BANK_W-1:0];
    end
  end
  // A pointer that names a virtual register ends on nothing
  assign sel_virt = indirect && (eff_addr == CSF_ADDR_VIND_A || eff_addr == CSF_ADDR_VIND_B);
  // Special registers sit in bank 0 only; addresses above the flags register, or outside bank 0 except the virtual ones, go to RAM
  assign sel_mem = !sel_virt && (eff_bank != '0 || eff_addr > CSF_ADDR_FLAGS);

  assign mem_rd_o = acc_rd_i && sel_mem;
  assign mem_wr_o = acc_wr_i && sel_mem;
  assign mem_addr_o = {eff_bank, eff_addr};
  assign mem_wdata_o = acc_wdata_i;

  // Read mux; data moves only via the work register, so one port suffices
  always_comb begin
    acc_rdata_o = CSF_RST_BYTE;
    if (sel_virt) acc_rdata_o = CSF_VIRT_READ;
    else if (sel_mem) acc_rdata_o = mem_rdata_i;
    else begin
      case (eff_addr)
        CSF_ADDR_PTR_A: acc_rdata_o = ptr_a_q;
        CSF_ADDR_PTR_B: acc_rdata_o = ptr_b_q;
        CSF_ADDR_BANK: acc_rdata_o = bank_q;
        CSF_ADDR_WORK: acc_rdata_o = work_q;
        CSF_ADDR_PCL: acc_rdata_o = pc_q[7:0];
        CSF_ADDR_TABLE_POINTER: acc_rdata_o = table_pointer_q;
        CSF_ADDR_TABLE_HIGH_BYTE: acc_rdata_o = table_high_byte_q;
        CSF_ADDR_FLAGS: acc_rdata_o = {2'b00, flags_q};
        default: acc_rdata_o = CSF_RST_BYTE;
      endcase
    end
  end

  function automatic logic hit(input logic [7:0] a);
    hit = acc_wr_i && !sel_mem && !sel_virt && eff_addr == a;
  endfunction : hit

  // Pointer registers behave as plain storage
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_a_q <= CSF_RST_BYTE;
      ptr_b_q <= CSF_RST_BYTE;
      bank_q <= CSF_RST_BYTE;
    end else begin
      if (hit(CSF_ADDR_PTR_A)) ptr_a_q <= acc_wdata_i;
      if (hit(CSF_ADDR_PTR_B)) ptr_b_q <= acc_wdata_i;
      if (hit(CSF_ADDR_BANK)) bank_q <= acc_wdata_i;
    end
  end

  // Work register holds ALU results and transfer data
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) work_q <= CSF_RST_BYTE;
    else if (work_ld_i) work_q <= work_d_i;
    else if (hit(CSF_ADDR_WORK)) work_q <= acc_wdata_i;
  end
  assign work_register_o = work_q;

  // Program counter; a low byte write keeps the page bits
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pc_q <= '0;
      dummy_q <= 1'b0;
    end else begin
      dummy_q <= hit(CSF_ADDR_PCL);
      if (hit(CSF_ADDR_PCL)) pc_q <= {pc_q[PC_W-1:8], acc_wdata_i};
      else if (pc_step_i && !dummy_q) pc_q <= pc_q + 1'b1;
    end
  end
  assign pc_o = pc_q;
  assign fetch_stall_o = dummy_q;

  // Table registers; the pointer must be valid before a read
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      table_pointer_q <= CSF_RST_BYTE;
      table_high_byte_q <= CSF_RST_BYTE;
      lo_q <= CSF_RST_BYTE;
    end else begin
      if (hit(CSF_ADDR_TABLE_POINTER)) table_pointer_q <= acc_wdata_i;
      if (tbl_rd_i) begin
        table_high_byte_q <= tbl_word_i[15:8];
        lo_q <= tbl_word_i[7:0];
      end else if (hit(CSF_ADDR_TABLE_HIGH_BYTE)) table_high_byte_q <= acc_wdata_i;
    end
  end
  assign table_pointer_o = table_pointer_q;
  assign tbl_low_o = lo_q;

  // ALU result and flag terms; subtract adds the inverse plus one
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    low7 = 8'h00;
    res = 8'h00;
    c_new = flags_q[CSF_BIT_C];
    ac_new = flags_q[CSF_BIT_AC];
    ov_new = flags_q[CSF_BIT_OV];
    arith = 1'b0;
    case (csf_op_e'(alu_op_i))
      CSF_OP_ADD, CSF_OP_SUB: begin
        arith = 1'b1;
        if (alu_op_i == CSF_OP_SUB) begin
          sum = {1'b0, alu_a_i} + {1'b0, ~alu_b_i} + 9'h001;
          nib = {1'b0, alu_a_i[3:0]} + {1'b0, ~alu_b_i[3:0]} + 5'h01;
          low7 = {1'b0, alu_a_i[6:0]} + {1'b0, ~alu_b_i[6:0]} + 8'h01;
        end else begin
          sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
          nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
          low7 = {1'b0, alu_a_i[6:0]} + {1'b0, alu_b_i[6:0]};
        end
        res = sum[7:0];
        c_new = sum[8];
        ac_new = nib[4];
        ov_new = low7[7] ^ sum[8];
      end
      CSF_OP_LOGIC: res = alu_a_i;
      CSF_OP_RLC: begin
        res = {alu_a_i[6:0], flags_q[CSF_BIT_C]};
        c_new = alu_a_i[7];
      end
      CSF_OP_RRC: begin
        res = {flags_q[CSF_BIT_C], alu_a_i[7:1]};
        c_new = alu_a_i[0];
      end
      default: res = alu_a_i;
    endcase
  end
  assign alu_result_o = res;

  // One process owns the whole flag register, so it has a single driver.
  // Arithmetic bits: an ALU update beats a register write in the same cycle.
  // System bits: a time-out beats its clears, halt beats the watchdog clear.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_q[3:0] <= CSF_RST_FLAGS[3:0];
      flags_q[CSF_BIT_TO] <= 1'b0;
      flags_q[CSF_BIT_PDF] <= 1'b0;
    end else begin
      if (hit(CSF_ADDR_FLAGS)) flags_q[3:0] <= acc_wdata_i[3:0];
      if (arith || alu_op_i == CSF_OP_RLC || alu_op_i == CSF_OP_RRC)
        flags_q[CSF_BIT_C] <= c_new;
      if (arith) begin
        flags_q[CSF_BIT_AC] <= ac_new;
        flags_q[CSF_BIT_OV] <= ov_new;
      end
      if (alu_zero_upd_i) flags_q[CSF_BIT_Z] <= (res == 8'h00);
      if (wdt_timeout_i) flags_q[CSF_BIT_TO] <= 1'b1;
      else if (watchdog_clear_instruction_i || halt_i) flags_q[CSF_BIT_TO] <= 1'b0;
      if (halt_i) flags_q[CSF_BIT_PDF] <= 1'b1;
      else if (watchdog_clear_instruction_i) flags_q[CSF_BIT_PDF] <= 1'b0;
    end
  end
  // Flags leave by this port and by a read of the flags address; no stack save path exists
  assign flags_o = {2'b00, flags_q};

  // Checks
  property p_virt_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i) sel_virt |-> acc_rdata_o == 8'h00 && !mem_wr_o;
  endproperty
  a_virt_zero: assert property (p_virt_zero) else $error("virtual read not zero");
  property p_ptr_a_bank;
    @(posedge ref_clk_i) disable iff (!rst_b_i) sel_a |-> mem_addr_o[BANK_W+7:8] == '0;
  endproperty
  a_ptr_a_bank: assert property (p_ptr_a_bank) else $error("pointer a left bank 0");
  property p_ind_addr;
    @(posedge ref_clk_i) disable iff (!rst_b_i) sel_b && mem_rd_o |-> mem_addr_o[7:0] == ptr_b_q;
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
  property p_pcl_jump;
    @(posedge ref_clk_i) disable iff (!rst_b_i) hit(CSF_ADDR_PCL) |=>
      pc_q[7:0] == $past(acc_wdata_i) && pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8]) && fetch_stall_o;
  endproperty
  a_pcl_jump: assert property (p_pcl_jump) else $error("pcl jump wrong");
  property p_dummy_one;
    @(posedge ref_clk_i) disable iff (!rst_b_i) fetch_stall_o |-> $past(hit(CSF_ADDR_PCL));
  endproperty
  a_dummy_one: assert property (p_dummy_one) else $error("stray dummy cycle");
  property p_tbl;
    @(posedge ref_clk_i) disable iff (!rst_b_i) tbl_rd_i |=> table_high_byte_q == $past(tbl_word_i[15:8]);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table high byte wrong");
  property p_sys_write;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !wdt_timeout_i && !halt_i && !watchdog_clear_instruction_i |=> $stable(flags_q[5:4]);
  endproperty
  a_sys_write: assert property (p_sys_write) else $error("system flag changed");
  property p_halt;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      halt_i && !wdt_timeout_i |=> flags_o[CSF_BIT_PDF] && !flags_o[CSF_BIT_TO];
  endproperty
  a_halt: assert property (p_halt) else $error("halt flags wrong");
  property p_upper;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      acc_rd_i && !sel_mem && !sel_virt && eff_addr == CSF_ADDR_FLAGS |->
      acc_rdata_o[7:6] == 2'b00 && flags_o[7:6] == 2'b00;
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag bits set");
  // Flag arithmetic judged by plain comparisons, not by the adder terms
  property p_add_carry;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      alu_op_i == CSF_OP_ADD |=> flags_o[CSF_BIT_C] == ($past(alu_b_i) > ~$past(alu_a_i));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
  property p_sub_carry;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      alu_op_i == CSF_OP_SUB |=> flags_o[CSF_BIT_C] == ($past(alu_a_i) >= $past(alu_b_i));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");
  property p_add_half;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      alu_op_i == CSF_OP_ADD |=>
      flags_o[CSF_BIT_AC] == ($past(alu_b_i[3:0]) > ~$past(alu_a_i[3:0]));
  endproperty
  a_add_half: assert property (p_add_half) else $error("half carry wrong");
  property p_add_ov;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      alu_op_i == CSF_OP_ADD |=> flags_o[CSF_BIT_OV] ==
      ($past(alu_a_i[7]) == $past(alu_b_i[7]) && $past(alu_result_o[7]) != $past(alu_a_i[7]));
  endproperty
  a_add_ov: assert property (p_add_ov) else $error("overflow wrong");
  property p_zero;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      alu_zero_upd_i |=> flags_o[CSF_BIT_Z] == ($past(alu_result_o) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_to_set;
    @(posedge ref_clk_i) disable iff (!rst_b_i) wdt_timeout_i |=> flags_o[CSF_BIT_TO];
  endproperty
  a_to_set: assert property (p_to_set) else $error("time-out not set");
  property p_wdt_clear;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      watchdog_clear_instruction_i && !halt_i && !wdt_timeout_i |=> flags_o[5:4] == 2'b00;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("clear flags wrong");
  property p_direct_bank;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !indirect && (mem_rd_o || mem_wr_o) |-> mem_addr_o[BANK_W+7:8] == '0;
  endproperty
  a_direct_bank: assert property (p_direct_bank) else $error("direct bank wrong");
  property p_work_ld;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      work_ld_i |=> work_register_o == $past(work_d_i);
  endproperty
  a_work_ld: assert property (p_work_ld) else $error("work load wrong");
  c_pcl: cover property (@(posedge ref_clk_i) hit(CSF_ADDR_PCL));
  c_ind_b: cover property (@(posedge ref_clk_i) sel_b && mem_wr_o && mem_addr_o[BANK_W+7:8] != '0);
  c_to: cover property (@(posedge ref_clk_i) wdt_timeout_i ##1 watchdog_clear_instruction_i);
  c_ov: cover property (@(posedge ref_clk_i) alu_op_i == CSF_OP_ADD ##1 flags_o[CSF_BIT_OV]);
  c_virt: cover property (@(posedge ref_clk_i) sel_virt && acc_wr_i);
endmodule : csf_regs

// [include/csf_pkg.sv]
// Package of constants for the core special function register block
package csf_pkg;
  // Special register addresses in the data space (bank 0)
  localparam logic [7:0] CSF_ADDR_VIND_A = 8'h00;
  localparam logic [7:0] CSF_ADDR_PTR_A = 8'h01;
  localparam logic [7:0] CSF_ADDR_VIND_B = 8'h02;
  localparam logic [7:0] CSF_ADDR_PTR_B = 8'h03;
  localparam logic [7:0] CSF_ADDR_BANK = 8'h04;
  localparam logic [7:0] CSF_ADDR_WORK = 8'h05;
  localparam logic [7:0] CSF_ADDR_PCL = 8'h06;
  localparam logic [7:0] CSF_ADDR_TABLE_POINTER = 8'h07;
  localparam logic [7:0] CSF_ADDR_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] CSF_ADDR_FLAGS = 8'h0a;
  // Flag bit positions
  localparam int CSF_BIT_C = 0;
  localparam int CSF_BIT_AC = 1;
  localparam int CSF_BIT_Z = 2;
  localparam int CSF_BIT_OV = 3;
  localparam int CSF_BIT_PDF = 4;
  localparam int CSF_BIT_TO = 5;
  // Value returned for an indirect access to a virtual register
  localparam logic [7:0] CSF_VIRT_READ = 8'h00;
  // Reset values of stored bytes
  localparam logic [7:0] CSF_RST_BYTE = 8'h00;
  localparam logic [7:0] CSF_RST_FLAGS = 8'h00;
  // Dummy cycles inserted after a program counter low byte write
  localparam int CSF_PCL_DUMMY = 1;
  // ALU operations
  typedef enum logic [2:0] {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_LOGIC,
    CSF_OP_RLC,
    CSF_OP_RRC
  } csf_op_e;
endpackage : csf_pkg

// [bench/csf_ram_model.sv]
// Behavioural general RAM that answers the resolved data port
module csf_ram_model #(
  parameter int BANK_W = 1
) (
  input wire logic ref_clk_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [BANK_W+7:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ram [2**(BANK_W+8)];
  logic [7:0] last_q = 8'h00;
  // Known contents, so a wrong address shows as a wrong value
  initial begin
    for (int i = 0; i < 2**(BANK_W+8); i++) ram[i] = 8'h00;
  end
  // Bank bits are part of the stored address
  always @(posedge ref_clk_i) begin
    if (mem_wr_i) ram[mem_addr_i] <= mem_wdata_i;
    if (mem_rd_i) last_q <= ram[mem_addr_i];
  end
  // An unselected read shows the inverse of the last value, never a stale match
  assign mem_rdata_o = mem_rd_i ? ram[mem_addr_i] : ~last_q;
endmodule : csf_ram_model

// [bench/test_cpu_special_function_regs.sv]
// Self-checking bench for the special function register block
module test_cpu_special_function_regs import csf_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int unsigned at; int kind; logic [15:0] v;} csf_note_s;
  logic ref_clk_i = 0, rst_b_i = 0, acc_rd_i = 0, acc_wr_i = 0, work_ld_i = 0;
  logic zupd = 0, pc_step_i = 0, tbl_rd_i = 0, wclr = 0, halt = 0, wto = 0;
  logic [7:0] acc_addr_i = 8'h00, acc_wdata_i = 8'h00, work_d_i = 8'h00;
  logic [7:0] alu_a_i = 8'h00, alu_b_i = 8'h00, fl, d;
  logic [2:0] alu_op_i = 3'h0;
  logic [15:0] tbl_word_i = 16'h0000;
  logic mem_rd, mem_wr, stall;
  logic [8:0] mem_addr;
  logic [7:0] rdata, mem_wdata, mem_rdata, work_q, alu_res, table_pointer, tbl_lo, flags;
  logic [10:0] pc;
  csf_note_s notes[$];
  int unsigned ncount = 0;
  int failures = 0, total_checks = 0;
  csf_op_e ops [5] = '{CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC, CSF_OP_RLC, CSF_OP_RRC};
  logic [7:0] ba [3] = '{8'h7f, 8'hff, 8'h0f};

  csf_regs dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .acc_rd_i(acc_rd_i),
    .acc_wr_i(acc_wr_i), .acc_addr_i(acc_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_rdata_o(rdata), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .work_ld_i(work_ld_i),
    .work_d_i(work_d_i), .work_register_o(work_q), .alu_op_i(alu_op_i), .alu_a_i(alu_a_i),
    .alu_b_i(alu_b_i), .alu_zero_upd_i(zupd), .alu_result_o(alu_res),
    .pc_step_i(pc_step_i), .pc_o(pc), .fetch_stall_o(stall), .tbl_rd_i(tbl_rd_i),
    .tbl_word_i(tbl_word_i), .table_pointer_o(table_pointer), .tbl_low_o(tbl_lo),
    .watchdog_clear_instruction_i(wclr), .halt_i(halt), .wdt_timeout_i(wto),
    .flags_o(flags));
  csf_ram_model ram (.ref_clk_i(ref_clk_i), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr),
    .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));

  // Clock at 50 MHz
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic tick();
    @(posedge ref_clk_i);
  endtask : tick
  // Note an expected result, due a given number of cycles from now
  task automatic want(input int k, input logic [15:0] v, input int unsigned dl = 0);
    notes.push_back('{ncount + dl, k, v});
  endtask : want
  task automatic tally(input logic ok, input string what);
    total_checks++;
    if (!ok) begin
      failures++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask : tally
  task automatic cmp_byte(input logic [7:0] a, e);
    tally(a === e, $sformatf("byte got %h want %h", a, e));
  endtask : cmp_byte
  task automatic cmp_pc(input logic [10:0] a, e);
    tally(a === e, $sformatf("pc got %h want %h", a, e));
  endtask : cmp_pc
  task automatic cmp_addr(input logic [8:0] a, e);
    tally(a === e, $sformatf("addr got %h want %h", a, e));
  endtask : cmp_addr
  task automatic cmp_bit(input logic a, e);
    tally(a === e, $sformatf("bit got %b want %b", a, e));
  endtask : cmp_bit
  // Watcher: outputs are settled at the falling edge, due notes are judged there
  always @(negedge ref_clk_i) begin : mon
    int i;
    i = 0;
    while (i < notes.size()) begin
      if (notes[i].at == ncount) begin
        case (notes[i].kind)
          0: cmp_byte(rdata, notes[i].v[7:0]);
          1: cmp_byte(flags, notes[i].v[7:0]);
          2: cmp_pc(pc, notes[i].v[10:0]);
          3: cmp_byte(alu_res, notes[i].v[7:0]);
          4: cmp_bit(stall, notes[i].v[0]);
          5: cmp_byte(tbl_lo, notes[i].v[7:0]);
          6: cmp_byte(table_pointer, notes[i].v[7:0]);
          8: cmp_byte(work_q, notes[i].v[7:0]);
          9: cmp_addr(mem_addr, notes[i].v[8:0]);
          10: cmp_bit(mem_rd, notes[i].v[0]);
          default: cmp_bit(mem_wr, notes[i].v[0]);
        endcase
        notes.delete(i);
      end else i++;
    end
    ncount++;
  end
  // Both strobes set every time, so back-to-back accesses never assign twice
  task automatic drv(input logic r, w, input logic [7:0] a, dv);
    acc_rd_i <= r;
    acc_wr_i <= w;
    acc_addr_i <= a;
    acc_wdata_i <= dv;
  endtask : drv
  task automatic wr(input logic [7:0] a, dv);
    drv(0, 1, a, dv);
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    drv(1, 0, a, 8'h00);
    want(0, e);
    tick();
  endtask : rd
  task automatic ev(input logic [2:0] e, input logic [7:0] f);
    {wto, halt, wclr} <= e;
    want(1, f, 1);
    tick();
  endtask : ev
  // Reference flag model: subtract is a plus inverted b plus one
  task automatic alu(input csf_op_e op, input logic [7:0] a, b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] m, t, r;
    logic sb;
    sb = (op == CSF_OP_SUB);
    m = sb ? ~b : b;
    s = {1'b0, a} + {1'b0, m} + 9'(sb);
    h = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'(sb);
    t = {1'b0, a[6:0]} + {1'b0, m[6:0]} + 8'(sb);
    r = s[7:0];
    if (op inside {CSF_OP_ADD, CSF_OP_SUB}) fl[3:0] = {t[7] ^ s[8], r == 8'h00, h[4], s[8]};
    else if (op == CSF_OP_LOGIC) begin
      r = a;
      fl[2] = (a == 8'h00);
    end else if (op == CSF_OP_RLC) begin
      r = {a[6:0], fl[0]};
      fl[0] = a[7];
    end else begin
      r = {fl[0], a[7:1]};
      fl[0] = a[0];
    end
    alu_op_i <= 3'(op);
    alu_a_i <= a;
    alu_b_i <= b;
    zupd <= (op inside {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC});
    want(3, r);
    want(1, fl, 1);
    tick();
  endtask : alu
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run of about 340 cycles
  initial begin
    #100us;
    failures++;
    $display("BAD t=%0t run did not complete", $time);
    end_sim();
  end
  // Main sequence
  initial begin
    void'($urandom(77));
    repeat (6) tick();
    rst_b_i <= 1;
    want(1, 8'h00);
    want(2, 16'h0000);
    tick();
    wr(CSF_ADDR_PTR_A, 8'h20);
    wr(CSF_ADDR_VIND_A, 8'h5a);
    rd(8'h20, 8'h5a);
    wr(CSF_ADDR_BANK, 8'h01);
    wr(CSF_ADDR_PTR_B, 8'h20);
    want(9, 16'h0120);
    wr(CSF_ADDR_VIND_B, 8'ha5);
    want(10, 16'h0001);
    rd(CSF_ADDR_VIND_B, 8'ha5);
    rd(CSF_ADDR_VIND_A, 8'h5a);
    rd(8'h20, 8'h5a);
    wr(CSF_ADDR_PTR_A, CSF_ADDR_VIND_B);
    rd(CSF_ADDR_PTR_A, CSF_ADDR_VIND_B);
    want(7, 16'h0000);
    wr(CSF_ADDR_VIND_A, 8'h77);
    rd(CSF_ADDR_VIND_A, CSF_VIRT_READ);
    want(10, 16'h0000);
    rd(8'h09, 8'h00);
    $display("test indirect finished");
    drv(0, 0, 8'h00, 8'h00);
    d = 8'($urandom());
    work_ld_i <= 1;
    work_d_i <= d;
    want(8, d, 1);
    tick();
    work_ld_i <= 0;
    rd(CSF_ADDR_WORK, d);
    tbl_word_i <= 16'($urandom());
    wr(CSF_ADDR_TABLE_POINTER, 8'h33);
    drv(0, 0, 8'h00, 8'h00);
    tbl_rd_i <= 1;
    want(6, 16'h0033);
    want(5, tbl_word_i[7:0], 1);
    tick();
    tbl_rd_i <= 0;
    rd(CSF_ADDR_TABLE_HIGH_BYTE, tbl_word_i[15:8]);
    $display("test table finished");
    drv(0, 0, 8'h00, 8'h00);
    pc_step_i <= 1;
    repeat (260) tick();
    want(2, 16'h0104);
    want(2, 16'h0137, 1);
    want(4, 16'h0001, 1);
    want(2, 16'h0137, 2);
    want(4, 16'h0000, 2);
    want(2, 16'h0138, 3);
    wr(CSF_ADDR_PCL, 8'h37);
    drv(0, 0, 8'h00, 8'h00);
    repeat (2) tick();
    pc_step_i <= 0;
    $display("test jump finished");
    want(1, 8'h0f, 1);
    wr(CSF_ADDR_FLAGS, 8'hff);
    drv(0, 0, 8'h00, 8'h00);
    ev(3'b100, 8'h2f);
    ev(3'b010, 8'h1f);
    ev(3'b100, 8'h3f);
    ev(3'b001, 8'h0f);
    ev(3'b101, 8'h2f);
    ev(3'b000, 8'h2f);
    want(1, 8'h20, 1);
    wr(CSF_ADDR_FLAGS, 8'h00);
    drv(0, 0, 8'h00, 8'h00);
    ev(3'b011, 8'h10);
    ev(3'b000, 8'h10);
    rd(CSF_ADDR_FLAGS, 8'h10);
    drv(0, 0, 8'h00, 8'h00);
    $display("test system flags finished");
    fl = 8'h10;
    for (int i = 0; i < 40; i++) begin
      if (i < 3) alu(CSF_OP_ADD, ba[i], 8'h01);
      else if (i == 3) alu(CSF_OP_LOGIC, 8'h00, 8'h5a);
      else alu(ops[$urandom_range(4)], 8'($urandom()), 8'($urandom()));
    end
    alu_op_i <= 3'(CSF_OP_NONE);
    zupd <= 0;
    want(1, fl, 1);
    repeat (2) tick();
    $display("test arithmetic flags finished");
    end_sim();
  end
endmodule : test_cpu_special_function_regs
